// [rtl/coupled_ram_pkg.sv]
package coupled_ram_pkg;

   // ****************************************************************
   // storage geometry
   // ****************************************************************
   localparam int ADDR_W         = 12;
   localparam int DEPTH          = 4096;
   localparam int DATA_W         = 64;
   localparam int CODE_W         = 8;
   localparam int STRB_W         = 8;
   localparam int BANKS          = 2;
   localparam int BYTES_PER_BANK = 4;
   localparam int CODE_PER_BANK  = 4;
   localparam int BANK_W         = 36;
   localparam int BYTE_W         = 8;

   // ****************************************************************
   // fixed values
   // ****************************************************************
   // check code of the all-zero word, written by auto-initialization
   localparam logic [CODE_W-1:0] INIT_CODE   = 8'h00;
   localparam logic [DATA_W-1:0] INIT_DATA   = 64'h0000000000000000;
   // address parity: 1'b0 even (bit makes total even), 1'b1 odd
   localparam logic              PARITY_ODD  = 1'b0;
   localparam logic [ADDR_W-1:0] ADDR_ZERO   = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_LAST   = 12'hFFF;
   localparam logic [ADDR_W-1:0] ADDR_ONE    = 12'h001;
   // byte lanes of bank 0, shifted by one for bank 1
   localparam logic [STRB_W-1:0] BANK0_LANES = 8'h55;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic                valid;
      logic                write;
      logic [ADDR_W-1:0]   addr;
      logic                addr_par;
      logic [STRB_W-1:0]   strb;
      logic [DATA_W-1:0]   wdata;
      logic [CODE_W-1:0]   wcode;
   } req_type;

   typedef struct packed {
      logic                valid;
      logic [DATA_W-1:0]   data;
      logic [CODE_W-1:0]   code;
   } rsp_type;

   typedef enum logic [0:0] {st_idle, st_init} state_type;

endpackage

// [rtl/coupled_ram_wrapper.sv]
`timescale 1ns/10ps

// Function
// - answer every read and write the core issues on its data tight port
// - each access carries a 64-bit word plus an 8-bit check code
// - reads return stored check code with the data; core does checking
// - writes store the core's check code nibble of each bank whose byte lanes are strobed
// - watch core event bus, raise single-bit or multibit error interrupt
// - capture addresses of single-bit and multibit errors, with flags
// - check parity on the address received from the core
// - duplicate bank and code select decoding, flag any mismatch
// - two byte-interleaved 36-bit banks, each with own write enable; address and read enable shared
// - auto-initialization writes both banks with valid check code
// - no bit-wise accesses; smallest write unit is one byte
module coupled_ram_wrapper
   import coupled_ram_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire req_type             core_req,
   output logic                     core_ready,
   output rsp_type                  core_rsp,
   input  wire logic                event_single,
   input  wire logic                event_multi,
   input  wire logic                single_err_clr,
   input  wire logic                multi_err_clr,
   output logic                     single_err_irq,
   output logic                     multi_err_irq,
   output logic [ADDR_W-1:0]        single_err_addr,
   output logic [ADDR_W-1:0]        multi_err_addr,
   output logic                     addr_par_err,
   output logic                     decode_err,
   input  wire logic                init_start,
   output logic                     init_busy
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   state_type                 state_reg;
   logic [ADDR_W-1:0]         init_addr_reg;
   logic [ADDR_W-1:0]         last_rd_addr_reg;
   logic                      single_flag_reg;
   logic                      multi_flag_reg;
   logic [ADDR_W-1:0]         single_addr_reg;
   logic [ADDR_W-1:0]         multi_addr_reg;
   logic                      par_err_reg;
   logic                      dec_err_reg;
   logic                      rvalid_reg;
   logic                      take;
   logic                      par_bad;
   logic [BANKS-1:0]          sel_a;
   logic [BANKS-1:0]          sel_b;
   logic [BANKS-1:0]          bank_we;
   logic [ADDR_W-1:0]         acc_addr;
   logic [STRB_W-1:0]         acc_strb;
   logic [DATA_W-1:0]         acc_data;
   logic [CODE_W-1:0]         acc_code;
   logic [BANK_W-1:0]         rd_q [BANKS];

   // ****************************************************************
   // request acceptance and address parity
   // ****************************************************************
   assign core_ready = (state_reg == st_idle);
   assign take       = core_req.valid && core_ready;
   assign par_bad    = ((^core_req.addr) ^ core_req.addr_par) != PARITY_ODD;

   // ****************************************************************
   // access mux: core or auto-initialization
   // ****************************************************************
   always_comb begin
      if (state_reg == st_init) begin
         acc_addr = init_addr_reg;
         acc_strb = '1;
         acc_data = INIT_DATA;
         acc_code = INIT_CODE;
      end else begin
         acc_addr = core_req.addr;
         acc_strb = core_req.strb;
         acc_data = core_req.wdata;
         acc_code = core_req.wcode;
      end
   end

   // ****************************************************************
   // duplicated select decoding
   // ****************************************************************
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         // decoder a: reduction over the bank's byte lanes
         sel_a[b] = |(acc_strb & (BANK0_LANES << b));
         // decoder b: lane-by-lane scan, built independently
         sel_b[b] = 1'b0;
         for (int i = 0; i < BYTES_PER_BANK; i++) begin
            sel_b[b] = sel_b[b] | acc_strb[2*i+b];
         end
      end
   end

   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         bank_we[b] = (state_reg == st_init) ||
                      (take && core_req.write && !par_bad && sel_a[b] && sel_b[b]);
      end
   end

   // ****************************************************************
   // storage banks
   // ****************************************************************
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      logic [BANK_W-1:0] mem [DEPTH];
      logic [BANK_W-1:0] q_reg;

      always_ff @(posedge clk) begin
         if (bank_we[b]) begin
            for (int i = 0; i < BYTES_PER_BANK; i++) begin
               if (acc_strb[2*i+b]) begin
                  mem[acc_addr][i*BYTE_W +: BYTE_W] <=
                     acc_data[(2*i+b)*BYTE_W +: BYTE_W];
               end
            end
            mem[acc_addr][BANK_W-1 -: CODE_PER_BANK] <=
               acc_code[b*CODE_PER_BANK +: CODE_PER_BANK];
         end
      end

      always_ff @(posedge clk) begin
         if (take && !core_req.write) begin
            q_reg <= mem[acc_addr];
         end
      end

      assign rd_q[b] = q_reg;
   end

   // ****************************************************************
   // read answer assembly
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= take;
      end
   end

   always_comb begin
      core_rsp.valid = rvalid_reg;
      core_rsp.data  = '0;
      core_rsp.code  = '0;
      for (int b = 0; b < BANKS; b++) begin
         for (int i = 0; i < BYTES_PER_BANK; i++) begin
            core_rsp.data[(2*i+b)*BYTE_W +: BYTE_W] = rd_q[b][i*BYTE_W +: BYTE_W];
         end
         core_rsp.code[b*CODE_PER_BANK +: CODE_PER_BANK] =
            rd_q[b][BANK_W-1 -: CODE_PER_BANK];
      end
   end

   // ****************************************************************
   // auto-initialization sequencer
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= st_idle;
         init_addr_reg <= ADDR_ZERO;
      end else begin
         case (state_reg)
            st_idle: begin
               if (init_start) begin
                  state_reg     <= st_init;
                  init_addr_reg <= ADDR_ZERO;
               end
            end
            st_init: begin
               if (init_addr_reg == ADDR_LAST) begin
                  state_reg <= st_idle;
               end
               init_addr_reg <= init_addr_reg + ADDR_ONE;
            end
            default: begin
               state_reg <= st_idle;
            end
         endcase
      end
   end

   assign init_busy = (state_reg == st_init);

   // ****************************************************************
   // error address capture
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_rd_addr_reg <= ADDR_ZERO;
      end else if (take && !core_req.write) begin
         last_rd_addr_reg <= core_req.addr;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         single_flag_reg <= 1'b0;
         single_addr_reg <= ADDR_ZERO;
      end else if (event_single) begin
         single_flag_reg <= 1'b1;
         if (!single_flag_reg || single_err_clr) begin
            single_addr_reg <= last_rd_addr_reg;
         end
      end else if (single_err_clr) begin
         single_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         multi_flag_reg <= 1'b0;
         multi_addr_reg <= ADDR_ZERO;
      end else if (event_multi) begin
         multi_flag_reg <= 1'b1;
         if (!multi_flag_reg || multi_err_clr) begin
            multi_addr_reg <= last_rd_addr_reg;
         end
      end else if (multi_err_clr) begin
         multi_flag_reg <= 1'b0;
      end
   end

   assign single_err_irq  = single_flag_reg;
   assign multi_err_irq   = multi_flag_reg;
   assign single_err_addr = single_addr_reg;
   assign multi_err_addr  = multi_addr_reg;

   // ****************************************************************
   // integrity error pulses
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         par_err_reg <= 1'b0;
         dec_err_reg <= 1'b0;
      end else begin
         par_err_reg <= take && par_bad;
         dec_err_reg <= (take || state_reg == st_init) && (sel_a != sel_b);
      end
   end

   assign addr_par_err = par_err_reg;
   assign decode_err   = dec_err_reg;

endmodule // coupled_ram_wrapper

// [dv/coupled_ram_sva.sv]
`timescale 1ns/10ps
module coupled_ram_checker
   import coupled_ram_pkg::*;
(
   input wire logic              clk,
   input wire logic              arst_n,
   input wire req_type           core_req,
   input wire logic              core_ready,
   input wire rsp_type           core_rsp,
   input wire logic              event_single,
   input wire logic              single_err_clr,
   input wire logic              single_err_irq,
   input wire logic [ADDR_W-1:0] single_err_addr,
   input wire logic              multi_err_irq,
   input wire logic              event_multi,
   input wire logic              multi_err_clr,
   input wire logic [ADDR_W-1:0] multi_err_addr,
   input wire logic              addr_par_err,
   input wire logic              decode_err,
   input wire logic              init_start,
   input wire logic              init_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_rsp_follows: assert property (core_req.valid && core_ready |=> core_rsp.valid)
      else $error("no answer to taken request");
   a_rsp_cause: assert property (core_rsp.valid |-> $past(core_req.valid && core_ready))
      else $error("answer without request");
   a_par_flag: assert property (core_req.valid && core_ready
      && ((^core_req.addr ^ core_req.addr_par) != PARITY_ODD) |=> addr_par_err)
      else $error("parity error not flagged");
   a_single_set: assert property (event_single |=> single_err_irq)
      else $error("single error not raised");
   a_single_clr: assert property (single_err_clr && !event_single |=> !single_err_irq)
      else $error("single flag not cleared");
   a_addr_kept: assert property (single_err_irq && !single_err_clr |=> $stable(single_err_addr))
      else $error("error address overwritten");
   a_init_run: assert property (init_start && !init_busy |=> init_busy [*8])
      else $error("init not running");
   a_init_block: assert property (init_busy |-> !core_ready)
      else $error("ready during init");
   a_decode_ok: assert property (!decode_err)
      else $error("decoders disagree");
   a_multi_set: assert property (event_multi |=> multi_err_irq)
      else $error("multibit error not raised");
   a_multi_clr: assert property (multi_err_clr && !event_multi |=> !multi_err_irq)
      else $error("multibit flag not cleared");
   a_multi_kept: assert property (multi_err_irq && !multi_err_clr
      |=> $stable(multi_err_addr))
      else $error("multibit address overwritten");
endmodule // coupled_ram_checker

// [dv/core_model.sv]
`timescale 1ns/10ps
module core_model
   import coupled_ram_pkg::*;
(
   input wire logic    clk,
   input wire logic    arst_n,
   input wire req_type core_req,
   input wire logic    core_ready,
   input wire rsp_type core_rsp,
   input wire logic    check_en,
   output logic        event_single,
   output logic        event_multi
);
   logic              rd_reg;
   logic [CODE_W-1:0] diff;
   always_comb begin
      for (int k = 0; k < CODE_W; k++) diff[k] = core_rsp.code[k] ^ (^core_rsp.data[8*k+:8]);
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_reg       <= 1'b0;
         event_single <= 1'b0;
         event_multi  <= 1'b0;
      end else begin
         rd_reg       <= core_req.valid && core_ready && !core_req.write;
         event_single <= check_en && rd_reg && $countones(diff) == 1;
         event_multi  <= check_en && rd_reg && $countones(diff) > 1;
      end
   end
endmodule // core_model

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   import coupled_ram_pkg::*;
   logic              clk = 1'b0, arst_n = 1'b0, check_en = 1'b0, init_start = 1'b0;
   logic              single_err_clr = 1'b0, multi_err_clr = 1'b0;
   req_type           core_req = '0;
   rsp_type           core_rsp;
   logic              core_ready, event_single, event_multi, single_err_irq, multi_err_irq;
   logic              addr_par_err, decode_err, init_busy;
   logic [ADDR_W-1:0] single_err_addr, multi_err_addr;
   logic [71:0]       rd;
   int                n_fail = 0, checks_done = 0;
   always #25 clk = ~clk;
   coupled_ram_wrapper u_dut (.clk(clk), .arst_n(arst_n), .core_req(core_req),
      .core_ready(core_ready), .core_rsp(core_rsp), .event_single(event_single),
      .event_multi(event_multi), .single_err_clr(single_err_clr), .multi_err_clr(multi_err_clr),
      .single_err_irq(single_err_irq), .multi_err_irq(multi_err_irq),
      .single_err_addr(single_err_addr), .multi_err_addr(multi_err_addr),
      .addr_par_err(addr_par_err), .decode_err(decode_err), .init_start(init_start),
      .init_busy(init_busy));
   core_model u_core (.clk(clk), .arst_n(arst_n), .core_req(core_req), .core_ready(core_ready),
      .core_rsp(core_rsp), .check_en(check_en), .event_single(event_single),
      .event_multi(event_multi));
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] pc(input logic [63:0] d);
      for (int k = 0; k < 8; k++) pc[k] = ^d[8*k+:8];
   endfunction
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] s,
                      input logic [63:0] d, input logic [7:0] c, input logic bad);
      core_req <= '{1'b1, w, a, (^a) ^ PARITY_ODD ^ bad, s, d, c};
      @(posedge clk);
      core_req.valid <= 1'b0;
      @(negedge clk);
      check(core_rsp.valid, 1'b1);
      check(addr_par_err, bad);
      check(decode_err, 1'b0);
      rd = {core_rsp.data, core_rsp.code};
      @(posedge clk);
   endtask
   task automatic t_init;
      int n = 0;
      init_start <= 1'b1;
      @(posedge clk);
      // second start while busy must be ignored
      @(posedge clk);
      init_start <= 1'b0;
      @(negedge clk);
      while (init_busy === 1'b1 && n < 5000) begin
         n++;
         @(negedge clk);
      end
      // busy 4096 cycles, the first one passed before counting
      check(n, 4095);
      @(posedge clk);
      acc(1'b0, ADDR_LAST, 8'h00, '0, '0, 1'b0);
      check(rd, {INIT_DATA, INIT_CODE});
   endtask
   task automatic t_bytes;
      acc(1'b1, 12'h005, 8'hFF, 64'h1122334455667788, 8'hA5, 1'b0);
      acc(1'b1, 12'h005, 8'h01, 64'hFFFFFFFFFFFFFF99, 8'h3C, 1'b0);
      acc(1'b1, 12'h005, 8'h02, 64'hFFFFFFFFFFFFEEFF, 8'h5A, 1'b0);
      acc(1'b1, 12'h005, 8'h00, 64'h0, 8'h00, 1'b0);
      acc(1'b1, 12'h005, 8'hFF, 64'h0, 8'h00, 1'b1);
      acc(1'b0, 12'h005, 8'h00, '0, '0, 1'b1);
      check(rd, {64'h112233445566EE99, 8'h5C});
   endtask
   task automatic t_err;
      check_en <= 1'b1;
      acc(1'b1, 12'h009, 8'hFF, 64'h0123456789ABCDEF, pc(64'h0123456789ABCDEF) ^ 8'h01, 1'b0);
      acc(1'b1, 12'h00A, 8'hFF, 64'h0F0F, pc(64'h0F0F) ^ 8'h03, 1'b0);
      acc(1'b1, 12'h00B, 8'hFF, 64'h00FF, pc(64'h00FF) ^ 8'h80, 1'b0);
      acc(1'b0, 12'h009, 8'h00, '0, '0, 1'b0);
      acc(1'b0, 12'h00A, 8'h00, '0, '0, 1'b0);
      // second single error while flagged: first address kept
      acc(1'b0, 12'h00B, 8'h00, '0, '0, 1'b0);
      repeat (2) @(negedge clk);
      check({single_err_irq, single_err_addr}, {1'b1, 12'h009});
      check({multi_err_irq, multi_err_addr}, {1'b1, 12'h00A});
      @(posedge clk);
      single_err_clr <= 1'b1;
      @(posedge clk);
      single_err_clr <= 1'b0;
      @(negedge clk);
      check({single_err_irq, multi_err_irq}, 2'b01);
      @(posedge clk);
      multi_err_clr <= 1'b1;
      @(posedge clk);
      multi_err_clr <= 1'b0;
      @(negedge clk);
      check({single_err_irq, multi_err_irq}, 2'b00);
      @(posedge clk);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(60000 * 50);
      n_fail++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      check({core_ready, init_busy, single_err_irq, multi_err_irq}, 4'b1000);
      @(posedge clk);
      t_init;
      t_bytes;
      t_err;
      finish_test;
   end
endmodule // tb_top
bind coupled_ram_wrapper coupled_ram_checker u_chk (.clk(clk), .arst_n(arst_n),
   .core_req(core_req), .core_ready(core_ready), .core_rsp(core_rsp),
   .event_single(event_single), .single_err_clr(single_err_clr),
   .single_err_irq(single_err_irq), .single_err_addr(single_err_addr),
   .multi_err_irq(multi_err_irq), .event_multi(event_multi), .multi_err_clr(multi_err_clr),
   .multi_err_addr(multi_err_addr), .addr_par_err(addr_par_err), .decode_err(decode_err),
   .init_start(init_start), .init_busy(init_busy));
